// *** rtl/add_and_bit_ops_execute.sv ***
/*
 * execute stage for literal and file add/and, bit set/clear and bit test skips.
 * assumes the fetch stage offers one instruction word per valid cycle and a
 * classic wishbone master reaches the control registers.
 */
`timescale 1ns/100ps
`include "alu_consts.svh"

// Notes on behaviour
// (RL1) add literal to accumulator, set flags
// (RL2) add accumulator and file register, set flags
// (RL3) destination bit picks accumulator or file
// (RL4) and literal into accumulator, zero flag only
// (RL5) and with file, routed, zero only
// (RL6) bit clear in file, flags untouched
// (RL7) bit set in file, flags untouched
// (RL8) skip next when tested bit zero
// (RL9) skip next when tested bit one
// (RL10) port operand comes from pin levels
// (RL11) carry bit7, digit bit3, zero on zero
module add_and_bit_ops_execute
    import alu_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // instruction from fetch
    input  wire logic [13:0] instr_i,
    input  wire logic        instr_valid_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // core state and pins
    input  wire logic [7:0]  port_pins_i,
    output logic      [7:0]  port_latch_o,
    output logic      [7:0]  acc_o,
    output logic      [2:0]  flags_o,
    output logic             squash_o
);
    op_t         op;
    exec_state_t state_reg, state_next;
    logic        run_reg, run_next;
    logic [7:0]  acc_reg, acc_next;
    logic [2:0]  flags_reg, flags_next;
    logic        squash_reg, squash_next;
    logic        ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic [7:0]  file_val, operand, result, wr_data;
    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic        exec_go, wr_en, dest_file, test_bit, bus_wr;
    logic [2:0]  bit_idx;
    logic [6:0]  faddr;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign faddr     = instr_i[6:0];
    assign bit_idx   = instr_i[9:7];
    assign dest_file = instr_i[`DEST_BIT];
    assign exec_go   = run_reg && instr_valid_i && (state_reg == exec_st);

    // opcode pattern match
    always_comb begin
        casez (instr_i[13:8])
            `PAT_ADD_LIT:   op = op_add_literal_to_acc;
            `PAT_AND_LIT:   op = op_and_literal_with_acc;
            `PAT_ADD_FILE:  op = op_add_acc_with_file;
            `PAT_AND_FILE:  op = op_and_acc_with_file;
            `PAT_BIT_CLR:   op = op_bit_clear_in_file;
            `PAT_BIT_SET:   op = op_bit_set_in_file;
            `PAT_SKIP_ZERO: op = op_test_skip_if_zero;
            `PAT_SKIP_ONE:  op = op_test_skip_if_one;
            default:        op = op_none;
        endcase
    end

    // ----------------------------------------------------------------
    // file bank
    // ----------------------------------------------------------------
    file_bank i_file_bank (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .rd_addr_i    (faddr),
        .rd_data_o    (file_val),
        .wr_en_i      (wr_en),
        .wr_addr_i    (faddr),
        .wr_data_i    (wr_data),
        .pins_i       (port_pins_i),
        .port_latch_o (port_latch_o)
    );

    // ----------------------------------------------------------------
    // datapath
    // ----------------------------------------------------------------
    always_comb begin
        if ((op == op_add_literal_to_acc) || (op == op_and_literal_with_acc)) begin
            operand = instr_i[7:0];
        end else begin
            operand = file_val; // port entry yields pins [RL10]
        end
        sum9     = {1'b0, acc_reg} + {1'b0, operand};
        sum5     = {1'b0, acc_reg[3:0]} + {1'b0, operand[3:0]};
        test_bit = file_val[bit_idx];
        if ((op == op_add_literal_to_acc) || (op == op_add_acc_with_file)) begin
            result = sum9[7:0];
        end else begin
            result = acc_reg & operand;
        end
    end

    // file write for routed results and bit ops
    always_comb begin
        wr_en   = 1'b0;
        wr_data = result;
        if (exec_go) begin
            case (op)
                op_add_acc_with_file, op_and_acc_with_file: begin
                    wr_en = dest_file; // [RL3]
                end
                op_bit_clear_in_file: begin
                    wr_en   = 1'b1;
                    wr_data = file_val & ~(8'h01 << bit_idx); // [RL6]
                end
                op_bit_set_in_file: begin
                    wr_en   = 1'b1;
                    wr_data = file_val | (8'h01 << bit_idx); // [RL7]
                end
                default: begin
                    wr_en = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // accumulator, flags and skip state
    // ----------------------------------------------------------------
    always_comb begin
        // a write lands on the edge at which the master sees ack, never earlier
        bus_wr      = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
        acc_next    = acc_reg;
        flags_next  = flags_reg;
        run_next    = run_reg;
        state_next  = state_reg;
        squash_next = 1'b0;
        // bus writes first, so a same-cycle instruction wins
        if (bus_wr && (wb_adr_i == `CTRL_OFS)) begin
            run_next = wb_dat_i[0];
        end else if (bus_wr && (wb_adr_i == `ACC_OFS)) begin
            acc_next = wb_dat_i[7:0];
        end else if (bus_wr && (wb_adr_i == `FLAGS_OFS)) begin
            flags_next = wb_dat_i[2:0];
        end
        case (state_reg)
            exec_st: begin
                if (exec_go) begin
                    case (op)
                        op_add_literal_to_acc, op_add_acc_with_file: begin
                            if ((op == op_add_literal_to_acc) || !dest_file) begin
                                acc_next = result; // [RL1] [RL2] [RL3]
                            end
                            flags_next[`FLAG_CARRY] = sum9[8]; // [RL11]
                            flags_next[`FLAG_DIGIT] = sum5[4]; // [RL11]
                            flags_next[`FLAG_ZERO]  = (sum9[7:0] == 8'h00); // [RL11]
                        end
                        op_and_literal_with_acc, op_and_acc_with_file: begin
                            if ((op == op_and_literal_with_acc) || !dest_file) begin
                                acc_next = result; // [RL4] [RL5]
                            end
                            flags_next[`FLAG_ZERO] = (result == 8'h00); // [RL4] [RL5]
                        end
                        op_test_skip_if_zero: begin
                            if (!test_bit) begin
                                state_next = squash_st; // [RL8]
                            end
                        end
                        op_test_skip_if_one: begin
                            if (test_bit) begin
                                state_next = squash_st; // [RL9]
                            end
                        end
                        default: begin
                            state_next = exec_st;
                        end
                    endcase
                end
            end
            squash_st: begin
                // next offered word is discarded as a no_operation cycle
                if (instr_valid_i) begin
                    state_next  = exec_st; // [RL8] [RL9]
                    squash_next = 1'b1;
                end
            end
            default: begin
                state_next = exec_st;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // wishbone slave answer, one wait state
    // ----------------------------------------------------------------
    always_comb begin
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        dat_next = 32'h0000_0000;
        if (wb_adr_i == `CTRL_OFS) begin
            dat_next = {31'h0000_0000, run_reg};
        end else if (wb_adr_i == `ACC_OFS) begin
            dat_next = {24'h00_0000, acc_reg};
        end else if (wb_adr_i == `FLAGS_OFS) begin
            dat_next = {28'h000_0000, (state_reg == squash_st), flags_reg};
        end
    end

    // register all state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg  <= exec_st;
            run_reg    <= `CTRL_RST;
            acc_reg    <= `ACC_RST;
            flags_reg  <= `FLAGS_RST;
            squash_reg <= 1'b0;
            ack_reg    <= 1'b0;
            dat_reg    <= 32'h0000_0000;
        end else begin
            state_reg  <= state_next;
            run_reg    <= run_next;
            acc_reg    <= acc_next;
            flags_reg  <= flags_next;
            squash_reg <= squash_next;
            ack_reg    <= ack_next;
            dat_reg    <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign acc_o    = acc_reg;
    assign flags_o  = flags_reg;
    assign squash_o = squash_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_add_lit_sum: assert property (exec_go && op == op_add_literal_to_acc // [RL1]
        |=> acc_reg == 8'($past(acc_reg) + $past(instr_i[7:0])))
        else $error("literal add wrong sum");
    a_add_file_carry: assert property (exec_go && op == op_add_acc_with_file // [RL2]
        |=> flags_reg[`FLAG_CARRY] == ((9'($past(acc_reg)) + 9'($past(file_val))) > 9'h0ff)
            && flags_reg[`FLAG_DIGIT]
               == ((5'($past(acc_reg[3:0])) + 5'($past(file_val[3:0]))) > 5'h0f))
        else $error("file add carry wrong");
    a_dest_to_file: assert property (exec_go && dest_file // [RL3]
        && (op == op_add_acc_with_file || op == op_and_acc_with_file)
        |-> wr_en ##1 $stable(acc_reg))
        else $error("file destination not honoured");
    a_and_lit_result: assert property (exec_go && op == op_and_literal_with_acc // [RL4]
        |=> acc_reg == ($past(acc_reg) & $past(instr_i[7:0])))
        else $error("literal and wrong");
    a_and_keeps_carry: assert property (exec_go && op == op_and_acc_with_file // [RL5]
        |=> flags_reg[1:0] == $past(flags_reg[1:0]))
        else $error("and touched carry flags");
    a_bit_clear_op: assert property (exec_go && op == op_bit_clear_in_file // [RL6]
        |-> wr_en && !wr_data[bit_idx] ##1 $stable(flags_reg))
        else $error("bit clear wrong");
    a_bit_set_op: assert property (exec_go && op == op_bit_set_in_file // [RL7]
        |-> wr_en && wr_data[bit_idx] ##1 $stable(flags_reg))
        else $error("bit set wrong");
    a_skip_zero_taken: assert property (exec_go && op == op_test_skip_if_zero && !test_bit // [RL8]
        ##1 instr_valid_i |=> squash_reg && state_reg == exec_st)
        else $error("skip on zero not taken");
    a_skip_one_taken: assert property (exec_go && op == op_test_skip_if_one // [RL9]
        |=> (state_reg == squash_st) == $past(test_bit))
        else $error("skip on one wrong");
    a_zero_flag: assert property (exec_go && op == op_add_literal_to_acc // [RL11]
        |=> flags_reg[`FLAG_ZERO] == (acc_reg == 8'h00))
        else $error("zero flag wrong");

    c_skip_done: cover property (squash_reg);
    c_add_carry: cover property (exec_go && op == op_add_acc_with_file && sum9[8]);
    c_bit_set:   cover property (exec_go && op == op_bit_set_in_file);
endmodule

// *** shared/alu_consts.svh ***
/*
 * offsets, field positions, reset values and opcode patterns of the execute block.
 * assumes inclusion by bare name wherever the constants are needed.
 */
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH

// ----------------------------------------------------------------
// wishbone register byte offsets
// ----------------------------------------------------------------
`define CTRL_OFS      8'h00
`define ACC_OFS       8'h04
`define FLAGS_OFS     8'h08
`define CTRL_RST      1'h0
`define ACC_RST       8'h00
`define FLAGS_RST     3'h0

// ----------------------------------------------------------------
// flag positions inside the flags register
// ----------------------------------------------------------------
`define FLAG_CARRY    0
`define FLAG_DIGIT    1
`define FLAG_ZERO     2

// ----------------------------------------------------------------
// instruction fields and opcode patterns on bits 13:8
// ----------------------------------------------------------------
`define FILE_ENTRIES  128
`define PORT_ADDR     7'h05
`define DEST_BIT      7
`define PAT_ADD_LIT   6'b11111?
`define PAT_AND_LIT   6'b111001
`define PAT_ADD_FILE  6'b000111
`define PAT_AND_FILE  6'b000101
`define PAT_BIT_CLR   6'b0100??
`define PAT_BIT_SET   6'b0101??
`define PAT_SKIP_ZERO 6'b0110??
`define PAT_SKIP_ONE  6'b0111??

`endif

// *** shared/alu_pkg.sv ***
/*
 * types shared by the execute block.
 * assumes nothing of its surroundings.
 */
package alu_pkg;
    typedef enum logic [3:0] {
        op_none,
        op_add_literal_to_acc,
        op_and_literal_with_acc,
        op_add_acc_with_file,
        op_and_acc_with_file,
        op_bit_clear_in_file,
        op_bit_set_in_file,
        op_test_skip_if_zero,
        op_test_skip_if_one
    } op_t;

    typedef enum logic {
        exec_st,
        squash_st
    } exec_state_t;
endpackage

// *** rtl/file_bank.sv ***
/*
 * 128 entry file register bank held in flip-flops, with one i/o port entry.
 * assumes a single clock; pins are asynchronous and are synchronised here.
 */
`timescale 1ns/100ps
`include "alu_consts.svh"

module file_bank (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // read side
    input  wire logic [6:0] rd_addr_i,
    output logic      [7:0] rd_data_o,
    // write side
    input  wire logic       wr_en_i,
    input  wire logic [6:0] wr_addr_i,
    input  wire logic [7:0] wr_data_i,
    // port pins
    input  wire logic [7:0] pins_i,
    output logic      [7:0] port_latch_o
);
    logic [7:0] mem_reg  [`FILE_ENTRIES];
    logic [7:0] mem_next [`FILE_ENTRIES];
    logic [7:0] pin_meta_reg;
    logic [7:0] pin_sync_reg;

    // ----------------------------------------------------------------
    // storage, one entry per generate step
    // ----------------------------------------------------------------
    for (genvar i = 0; i < `FILE_ENTRIES; i++) begin : g_entry
        always_comb begin
            mem_next[i] = mem_reg[i];
            if (wr_en_i && (wr_addr_i == 7'(i))) begin
                mem_next[i] = wr_data_i;
            end
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                mem_reg[i] <= 8'h00;
            end else begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end

    // two stage pin synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end else begin
            pin_meta_reg <= pins_i;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // the port entry reads pin levels, not its latch [RL10]
    always_comb begin
        if (rd_addr_i == `PORT_ADDR) begin
            rd_data_o = pin_sync_reg;
        end else begin
            rd_data_o = mem_reg[rd_addr_i];
        end
    end

    assign port_latch_o = mem_reg[`PORT_ADDR];

    // pin levels seen two edges earlier, once the synchroniser has refilled after reset
    a_port_reads_pins: assert property (@(posedge clk_i) disable iff (rst_i) // [RL10]
        rd_addr_i == `PORT_ADDR && !$past(rst_i, 2) |-> rd_data_o == $past(pins_i, 2))
        else $error("port read did not return pin levels");
endmodule

// *** verification/fetch_model.sv ***
/*
 * fetch stage model: hands queued instruction words to the execute block.
 * assumes one clock; the bench queues words through push.
 */
`timescale 1ns/100ps

module fetch_model (
    // clock
    input  wire logic        clk_i,
    // instruction out
    output logic      [13:0] instr_o,
    output logic             instr_valid_o
);
    logic [13:0] word_q[$];

    // quiet outputs from time zero
    initial begin
        instr_o       = 14'h0000;
        instr_valid_o = 1'b0;
    end

    // queue a word for a later edge
    task automatic push(input logic [13:0] w);
        word_q.push_back(w);
    endtask

    // one word per edge; idle words toggle so a stale word never looks steady
    always @(posedge clk_i) begin
        if (word_q.size() != 0) begin
            instr_o       <= word_q.pop_front();
            instr_valid_o <= 1'b1;
        end else begin
            instr_o       <= ~instr_o;
            instr_valid_o <= 1'b0;
        end
    end
endmodule

// *** verification/tb_add_and_bit_ops_execute.sv ***
/*
 * self-checking bench for the execute block: bus tasks and instruction runs.
 * assumes the fetch model and the design files are compiled before it.
 */
`timescale 1ns/100ps
`include "alu_consts.svh"

module tb_add_and_bit_ops_execute;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [13:0] instr;
    logic        instr_valid;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic [7:0]  pins = 8'h00;
    logic [7:0]  latch;
    logic [7:0]  acc;
    logic [2:0]  flags;
    logic        squash;
    int          num_errors = 0;
    int          num_checks = 0;
    int          squash_cnt = 0;
    int          cnt;
    logic [31:0] rd;
    logic [8:0]  sum;
    logic        dc;
    logic [7:0]  tab_a[4] = '{8'h0f, 8'hff, 8'h80, 8'h12};
    logic [7:0]  tab_k[4] = '{8'h01, 8'h01, 8'h80, 8'h34};
    logic [4:0]  tab_s[6] = '{5'b00001, 5'b00010, 5'b01101, 5'b10011, 5'b10000, 5'b11111};

    // ----------------------------------------------------------------
    // clock, instances, squash counter
    // ----------------------------------------------------------------
    always #2 clk_i = ~clk_i;

    fetch_model i_fetch_model (.clk_i(clk_i), .instr_o(instr), .instr_valid_o(instr_valid));

    add_and_bit_ops_execute i_add_and_bit_ops_execute (
        .clk_i(clk_i), .rst_i(rst_i), .instr_i(instr), .instr_valid_i(instr_valid),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
        .port_pins_i(pins), .port_latch_o(latch), .acc_o(acc), .flags_o(flags),
        .squash_o(squash));

    always @(posedge clk_i) begin
        if (squash === 1'b1) begin
            squash_cnt++;
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // classic single cycle; request held until ack is seen at an edge
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_sel   <= 4'hf;
        wb_dat_w <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
        end
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic set_state(input logic [7:0] a, input logic [2:0] f);
        logic [31:0] q;
        wb_xfer(1'b1, `ACC_OFS, {24'h0, a}, q);
        wb_xfer(1'b1, `FLAGS_OFS, {29'h0, f}, q);
    endtask

    function automatic logic [13:0] w6(input logic [5:0] op, input logic [7:0] lo);
        return {op, lo};
    endfunction

    function automatic logic [13:0] w4(input logic [3:0] op, input int b, input logic [6:0] f);
        return {op, b[2:0], f};
    endfunction

    task automatic run_instr(input logic [13:0] w);
        i_fetch_model.push(w);
        repeat (4) @(posedge clk_i);
    endtask

    // file entry copied into the accumulator by adding it to zero
    task automatic read_file(input logic [6:0] f, output logic [7:0] v);
        set_state(8'h00, 3'h0);
        run_instr(w6(6'b000111, {1'b0, f}));
        v = acc;
    endtask

    task automatic complete_run;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end

    initial begin
        logic [7:0] v;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, an unmapped place, and instructions ignored while stopped
        wb_xfer(1'b0, `FLAGS_OFS, 32'h0, rd);
        check(rd, 32'h0);
        wb_xfer(1'b1, 8'h0c, 32'hff, rd);
        wb_xfer(1'b0, 8'h0c, 32'h0, rd);
        check(rd, 32'h0);
        run_instr(w6(6'b111110, 8'h55));
        check({24'h0, acc}, 32'h0);
        wb_xfer(1'b1, `CTRL_OFS, 32'h1, rd);
        // add literal over carry and digit boundaries, both encodings
        for (int i = 0; i < 4; i++) begin
            set_state(tab_a[i], 3'h0);
            run_instr(w6({5'b11111, i[0]}, tab_k[i]));
            sum = {1'b0, tab_a[i]} + {1'b0, tab_k[i]};
            dc = ({1'b0, tab_a[i][3:0]} + {1'b0, tab_k[i][3:0]}) > 5'h0f;
            check({24'h0, acc}, {24'h0, sum[7:0]});
            check({29'h0, flags}, {29'h0, sum[7:0] == 8'h00, dc, sum[8]});
        end
        // and literal keeps carry and digit carry
        set_state(8'hf0, 3'b011);
        run_instr(w6(6'b111001, 8'h0f));
        check({21'h0, flags, acc}, {21'h0, 3'b111, 8'h00});
        set_state(8'hff, 3'b100);
        run_instr(w6(6'b111001, 8'h3c));
        check({21'h0, flags, acc}, {21'h0, 3'b000, 8'h3c});
        // add with file, result routed by the destination bit
        set_state(8'h5a, 3'h0);
        run_instr(w6(6'b000111, {1'b1, 7'h20}));
        check({24'h0, acc}, 32'h5a);
        read_file(7'h20, v);
        check({24'h0, v}, 32'h5a);
        set_state(8'hc3, 3'h0);
        run_instr(w6(6'b000111, {1'b1, 7'h7f}));
        set_state(8'h80, 3'h0);
        run_instr(w6(6'b000111, {1'b0, 7'h7f}));
        check({21'h0, flags, acc}, {21'h0, 3'b001, 8'h43});
        // and with file, both destinations
        set_state(8'h0f, 3'h0);
        run_instr(w6(6'b000101, {1'b1, 7'h20}));
        check({24'h0, acc}, 32'h0f);
        read_file(7'h20, v);
        check({24'h0, v}, 32'h0a);
        set_state(8'ha0, 3'b011);
        run_instr(w6(6'b000101, {1'b0, 7'h20}));
        check({21'h0, flags, acc}, {21'h0, 3'b111, 8'h00});
        // set every bit, clear the even ones, flags untouched
        set_state(8'h00, 3'b101);
        for (int b = 0; b < 8; b++) begin
            run_instr(w4(4'b0101, b, 7'h31));
        end
        for (int b = 0; b < 8; b += 2) begin
            run_instr(w4(4'b0100, b, 7'h31));
        end
        check({29'h0, flags}, {29'h0, 3'b101});
        read_file(7'h31, v);
        check({24'h0, v}, 32'haa);
        // bit tests followed back to back by an add literal
        for (int i = 0; i < 6; i++) begin
            set_state(8'h10, 3'h0);
            cnt = squash_cnt;
            i_fetch_model.push(w4({3'b011, tab_s[i][4]}, int'(tab_s[i][3:1]), 7'h31));
            run_instr(w6(6'b111110, 8'h01));
            repeat (2) @(posedge clk_i);
            check({24'h0, acc}, tab_s[i][0] ? 32'h10 : 32'h11);
            check(squash_cnt - cnt, {31'h0, tab_s[i][0]});
        end
        // port entry operand taken from the pins
        pins <= 8'h3c;
        repeat (4) @(posedge clk_i);
        run_instr(w4(4'b0101, 0, `PORT_ADDR));
        check({24'h0, latch}, 32'h3d);
        read_file(`PORT_ADDR, v);
        check({24'h0, v}, 32'h3c);
        complete_run();
    end
endmodule
